/* bench/sfk_cipher_props.sv */
`timescale 1ns/1ps
module sfk_cipher_chk (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_enc_mode,
  input wire logic i_frame_start,
  input wire logic o_ksg_init,
  input wire logic o_ks_ready,
  input wire logic i_fld_valid,
  input wire logic o_fld_ready,
  input wire logic o_out_valid,
  input wire logic o_out_bit,
  input wire logic o_out_first,
  input wire logic i_out_ready,
  input wire logic o_frame_enc,
  input wire logic o_field_done
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  a_init_pulse: assert property (i_frame_start && i_enc_mode |=> o_ksg_init && o_frame_enc)
    else $error("init missing after encrypted frame start");
  a_clear_frame: assert property (i_frame_start && !i_enc_mode |=> !o_ksg_init && !o_frame_enc)
    else $error("clear frame started the generator");
  a_init_once: assert property (o_ksg_init |=> !o_ksg_init)
    else $error("init longer than one cycle");
  a_key_idle: assert property (!o_frame_enc |-> !o_ks_ready)
    else $error("key taken in clear frame");
  a_key_open: assert property (o_ksg_init && !i_frame_start |-> o_ks_ready)
    else $error("key intake not open after init");
  a_out_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_bit) && $stable(o_out_first))
    else $error("output changed under stall");
  a_out_cause: assert property ($rose(o_out_valid) |-> $past(i_fld_valid && o_fld_ready))
    else $error("output without accepted bit");
  a_done_once: assert property (o_field_done |=> !o_field_done)
    else $error("done longer than one cycle");
  // reset itself is the antecedent here, so this one is never disabled
  a_rst_clear: assert property (disable iff (1'b0) i_sys_rst |=> !o_out_valid && !o_ksg_init && !o_frame_enc)
    else $error("state not cleared by reset");
endmodule
bind sfk_cipher sfk_cipher_chk sfk_cipher_chk_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_enc_mode(i_enc_mode), .i_frame_start(i_frame_start), .o_ksg_init(o_ksg_init), .o_ks_ready(o_ks_ready),
  .i_fld_valid(i_fld_valid), .o_fld_ready(o_fld_ready), .o_out_valid(o_out_valid), .o_out_bit(o_out_bit),
  .o_out_first(o_out_first), .i_out_ready(i_out_ready), .o_frame_enc(o_frame_enc), .o_field_done(o_field_done));

/* bench/sfk_ksg_model.sv */
`timescale 1ns/1ps
module sfk_ksg_model (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_init,
  input  wire logic i_ready,
  input  wire logic i_slow,
  output logic      o_valid,
  output logic      o_bit
);
  int   idx = 720;
  int   n;
  logic take = 0;
  logic ini  = 0;
  logic ph   = 0;
  logic v;
  initial {o_valid, o_bit} = 2'h0;
  function automatic logic kb(int k);
    return ((k * 37 + k / 5) >> 2) % 2 == 1;
  endfunction
  // sample on the falling edge so the registered handshake is settled
  always @(negedge i_core_clk) begin
    take = o_valid && i_ready;
    ini  = i_init;
  end
  always @(posedge i_core_clk) begin
    n = ini ? 0 : (take ? idx + 1 : idx);
    if (i_sys_rst) n = 720;
    v = !i_sys_rst && ((o_valid && !take && !ini) || (n < 720 && (!i_slow || ph)));
    idx     <= n;
    ph      <= ~ph;
    o_valid <= v;
    // a released line shows the inverse, never a stale bit
    o_bit   <= v ? kb(n) : ~o_bit;
  end
endmodule

/* bench/test_slot_field_keystream_cipher.sv */
`timescale 1ns/1ps
module test_slot_field_keystream_cipher;
  import sfk_pkg::*;
  logic       clk, rst, enc, fix, fs, kinit, ksv, ksb, ksr, slow;
  logic       fv, fb, ff, ftx, fr, ov, ob, of, ordy, fenc, done, abt, kw;
  logic [1:0] q[$];
  int         error_cnt = 0;
  int         n_tests   = 0;
  int         done_cnt  = 0;
  int         cyc       = 0;
  int         abort_cnt = 0;
  int         wait_cnt  = 0;
  sfk_cipher sfk_cipher_i (.i_core_clk(clk), .i_sys_rst(rst), .i_enc_mode(enc), .i_fixed_side(fix),
    .i_frame_start(fs), .o_ksg_init(kinit), .i_ks_valid(ksv), .i_ks_bit(ksb), .o_ks_ready(ksr),
    .i_fld_valid(fv), .i_fld_bit(fb), .i_fld_first(ff), .i_fld_tx(ftx), .o_fld_ready(fr),
    .o_out_valid(ov), .o_out_bit(ob), .o_out_first(of), .i_out_ready(ordy), .o_frame_enc(fenc),
    .o_field_done(done), .o_field_abort(abt), .o_key_wait(kw));
  sfk_ksg_model sfk_ksg_model_i (.i_core_clk(clk), .i_sys_rst(rst), .i_init(kinit), .i_ready(ksr),
    .i_slow(slow), .o_valid(ksv), .o_bit(ksb));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic kb(int k);
    return ((k * 37 + k / 5) >> 2) % 2 == 1;
  endfunction
  function automatic logic fbit(int n, logic [7:0] h);
    return n < 8 ? h[n] : ((n * 13) >> 1) % 2 == 1;
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // receiver stalls one cycle in four so the buffer fills
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    ordy <= !rst && cyc % 4 != 3;
  end
  always @(negedge clk) begin
    if (ov && ordy) q.push_back({of, ob});
    if (done) done_cnt++;
    if (abt) abort_cnt++;
    if (kw) wait_cnt++;
  end
  task automatic frame(logic e);
    @(posedge clk);
    enc <= e;
    fs  <= 1;
    @(posedge clk);
    fs  <= 0;
    @(negedge clk);
    chk(fenc, e);
  endtask
  task automatic field(logic e, logic t, logic [7:0] h);
    logic x;
    int   seg;
    int   b;
    int   dn;
    seg = (fix == t) ? 0 : 360;
    dn = done_cnt;
    q.delete();
    for (int n = 0; n < 388; n++) begin
      @(posedge clk);
      fv  <= 1;
      fb  <= fbit(n, h);
      ff  <= (n == 0);
      ftx <= t;
      do @(negedge clk); while (fr !== 1'b1);
    end
    @(posedge clk);
    fv <= 0;
    repeat (40) @(posedge clk);
    chk(q.size(), 388);
    for (int n = 0; n < q.size() && n < 388; n++) begin
      x = fbit(n, h);
      b = n - 64;
      if (e && n >= 8 && n < 48 && h[3:1] == TAIL_CTRL) x ^= kb(seg + n - 8);
      if (e && b >= 0 && b < 320 && (h[6:4] == FMT_UNPROT || b % 80 < 64)) x ^= kb(seg + 40 + b);
      chk(q[n], {n == 0, x});
    end
    chk(done_cnt - dn, 1);
  endtask
  task automatic t_clear;
    @(posedge clk);
    fix <= 1;
    frame(0);
    field(0, 1, 8'h14);
  endtask
  task automatic t_abort;
    int ab;
    ab = abort_cnt;
    frame(0);
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      fv  <= 1;
      fb  <= fbit(n, 8'h72);
      ff  <= (n == 0);
      ftx <= 1;
      do @(negedge clk); while (fr !== 1'b1);
    end
    @(posedge clk);
    fv <= 0;
    repeat (8) @(posedge clk);
    field(0, 1, 8'h72);
    chk(abort_cnt - ab, 1);
  endtask
  task automatic t_fixed;
    frame(1);
    field(1, 1, 8'h04);
    field(1, 0, 8'h72);
  endtask
  task automatic t_portable;
    int w0;
    w0 = wait_cnt;
    @(posedge clk);
    fix  <= 0;
    slow <= 1;
    frame(1);
    field(1, 1, 8'h14);
    field(1, 0, 8'h0A);
    chk(wait_cnt > w0, 1);
  endtask
  initial begin
    rst = 1;
    {enc, fix, fs, fv, fb, ff, ftx, slow} = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 0;
    t_clear;
    t_abort;
    t_fixed;
    t_portable;
    give_verdict;
  end
  initial begin
    #400000;
    error_cnt++;
    give_verdict;
  end
endmodule

/* hdl/sfk_buf2.sv */
`timescale 1ns/1ps
module sfk_buf2 import sfk_pkg::*; #(
  parameter int unsigned W = 2
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  logic [W-1:0] mem_ff [2];
  logic [W-1:0] nxt_mem [2];
  logic         wp_ff;
  logic         nxt_wp;
  logic         rp_ff;
  logic         nxt_rp;
  logic [1:0]   cnt_ff;
  logic [1:0]   nxt_cnt;
  logic         push;
  logic         pop;

  assign o_in_ready  = (cnt_ff != 2'h2);
  assign o_out_valid = (cnt_ff != 2'h0);
  assign o_out_data  = mem_ff[rp_ff];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wp_ff] = i_in_data;
      nxt_wp         = ~wp_ff;
    end
    if (pop) begin
      nxt_rp = ~rp_ff;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wp_ff     <= 1'b0;
      rp_ff     <= 1'b0;
      cnt_ff    <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

/* hdl/sfk_cipher.sv */
`timescale 1ns/1ps
module sfk_cipher import sfk_pkg::*; (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_enc_mode,
  input  wire logic i_fixed_side,
  input  wire logic i_frame_start,
  output logic      o_ksg_init,
  input  wire logic i_ks_valid,
  input  wire logic i_ks_bit,
  output logic      o_ks_ready,
  input  wire logic i_fld_valid,
  input  wire logic i_fld_bit,
  input  wire logic i_fld_first,
  input  wire logic i_fld_tx,
  output logic      o_fld_ready,
  output logic      o_out_valid,
  output logic      o_out_bit,
  output logic      o_out_first,
  input  wire logic i_out_ready,
  output logic      o_frame_enc,
  output logic      o_field_done,
  output logic      o_field_abort,
  output logic      o_key_wait
);

  localparam int unsigned SUB_CNT = DATA_BITS / SUB_BITS;

  typedef enum logic [2:0] {
    RGN_HDR  = 3'b000,
    RGN_TAIL = 3'b001,
    RGN_FCRC = 3'b010,
    RGN_DATA = 3'b011,
    RGN_XCRC = 3'b100
  } sfk_rgn_t;

  sfk_fld_t    fld_ff;
  sfk_fld_t    nxt_fld;
  logic [8:0]  pos_ff;
  logic [8:0]  nxt_pos;
  logic [7:0]  hdr_ff;
  logic [7:0]  nxt_hdr;
  logic        seg2_ff;
  logic        nxt_seg2;
  logic        frm_enc_ff;
  logic        nxt_frm_enc;
  logic        init_ff;
  logic        nxt_init;
  logic [9:0]  ks_cnt_ff;
  logic [9:0]  nxt_ks_cnt;
  logic        ks_mem_ff [PAIR_BITS];
  logic        nxt_ks_mem [PAIR_BITS];
  logic        ks_store;
  logic        done_ff;
  logic        nxt_done;
  logic        abort_ff;
  logic        nxt_abort;
  logic        wait_ff;
  logic        nxt_wait;

  logic        ks_take;
  logic [8:0]  cur_pos;
  logic        cur_seg2;
  logic [2:0]  tail_code;
  logic [2:0]  fmt_code;
  logic        tail_ctrl;
  logic        fmt_prot;
  logic [8:0]  data_off;
  logic [SUB_CNT-1:0] sub_in;
  logic [SUB_CNT-1:0] sub_run;
  sfk_rgn_t    rgn;
  logic        role_seg2;
  logic        key_use;
  logic [9:0]  key_idx;
  logic        key_here;
  logic        key_bit;
  logic        buf_in_ready;
  logic        accept;
  logic        ciph_bit;
  logic [1:0]  buf_out;

  // key stream intake: whole pair is kept so the two fields of a frame may come in either order
  // ready drops in the start cycle so a count restart and a take never coincide
  assign ks_take    = frm_enc_ff && (ks_cnt_ff <= PAIR_LAST) && !i_frame_start;
  assign ks_store   = ks_take && i_ks_valid;
  assign o_ks_ready = ks_take;
  assign o_ksg_init = init_ff;

  always_comb begin
    nxt_frm_enc = frm_enc_ff;
    nxt_ks_cnt  = ks_cnt_ff;
    nxt_init    = 1'b0;
    if (i_frame_start) begin
      nxt_frm_enc = i_enc_mode;
      nxt_ks_cnt  = '0;
      nxt_init    = i_enc_mode;
    end else if (ks_store) begin
      nxt_ks_cnt = ks_cnt_ff + 10'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      frm_enc_ff <= 1'b0;
      ks_cnt_ff  <= '0;
      init_ff    <= 1'b0;
    end else begin
      frm_enc_ff <= nxt_frm_enc;
      ks_cnt_ff  <= nxt_ks_cnt;
      init_ff    <= nxt_init;
    end
  end

  // storage only, no reset needed: a bit is read only after its count has passed
  always_comb begin
    nxt_ks_mem = ks_mem_ff;
    if (ks_store) begin
      nxt_ks_mem[ks_cnt_ff] = i_ks_bit;
    end
  end

  always_ff @(posedge i_core_clk) begin
    ks_mem_ff <= nxt_ks_mem;
  end

  // position and header decode
  assign cur_pos   = i_fld_first ? 9'h000 : pos_ff;
  assign cur_seg2  = i_fld_first ? role_seg2 : seg2_ff;
  assign tail_code = hdr_ff[HDR_TAIL_LSB +: 3];
  assign fmt_code  = hdr_ff[HDR_FMT_LSB +: 3];

  // role table: fixed sends on the first half, portable sends on the second
  always_comb begin
    role_seg2 = 1'b0;
    case ({i_fixed_side, i_fld_tx})
      2'b10: role_seg2 = 1'b1;
      2'b01: role_seg2 = 1'b1;
      2'b11: role_seg2 = 1'b0;
      2'b00: role_seg2 = 1'b0;
      default: role_seg2 = 1'b0;
    endcase
  end

  // only the control tail code opens the tail to key
  always_comb begin
    tail_ctrl = 1'b0;
    case (tail_code)
      TAIL_CTRL: tail_ctrl = 1'b1;
      default:   tail_ctrl = 1'b0;
    endcase
  end

  // any code but the unprotected one means four sub-blocks with crcs
  always_comb begin
    fmt_prot = 1'b1;
    case (fmt_code)
      FMT_UNPROT: fmt_prot = 1'b0;
      default:    fmt_prot = 1'b1;
    endcase
  end

  // header and both crc stretches get regions of their own, so no key path reaches them
  always_comb begin
    rgn = RGN_HDR;
    if (cur_pos > POS_DATA_LAST) begin
      rgn = RGN_XCRC;
    end else if (cur_pos >= POS_DATA_FIRST) begin
      rgn = RGN_DATA;
    end else if (cur_pos > POS_TAIL_LAST) begin
      rgn = RGN_FCRC;
    end else if (cur_pos >= POS_TAIL_FIRST) begin
      rgn = RGN_TAIL;
    end
  end
  assign data_off = cur_pos - POS_DATA_FIRST;

  // one window per sub-block; its crc is the stretch past the data run
  for (genvar j = 0; j < SUB_CNT; j++) begin : g_sub
    localparam logic [8:0] SUB_LO  = 9'(j * SUB_BITS);
    localparam logic [8:0] SUB_HI  = 9'((j + 1) * SUB_BITS);
    localparam logic [8:0] RUN_END = 9'(j * SUB_BITS + SUB_DATA);
    assign sub_in[j]  = (data_off >= SUB_LO) && (data_off < SUB_HI);
    assign sub_run[j] = sub_in[j] && (data_off < RUN_END);
  end

  // header, first crc and second crc fall in neither window, so they never see key
  always_comb begin
    key_use = 1'b0;
    key_idx = '0;
    case (rgn)
      RGN_TAIL: begin
        key_use = frm_enc_ff && tail_ctrl;
        key_idx = KS_TAIL_BASE + 10'(cur_pos - POS_TAIL_FIRST);
      end
      RGN_DATA: begin
        key_use = frm_enc_ff && (!fmt_prot || (|sub_run));
        key_idx = KS_DATA_BASE + 10'(data_off);
      end
      default: begin
        key_use = 1'b0;
      end
    endcase
    if (cur_seg2) begin
      key_idx = key_idx + SEG_SECOND;
    end
  end

  // unused segment bits are still addressed, but key_use masks them off, which discards them
  assign key_here = (ks_cnt_ff > key_idx);
  assign key_bit  = ks_mem_ff[key_idx];
  assign ciph_bit = i_fld_bit ^ (key_use && key_bit);
  assign accept   = i_fld_valid && buf_in_ready && (!key_use || key_here);
  assign o_fld_ready = buf_in_ready && (!key_use || key_here);

  always_comb begin
    nxt_fld   = fld_ff;
    nxt_pos   = pos_ff;
    nxt_hdr   = hdr_ff;
    nxt_seg2  = seg2_ff;
    case (fld_ff)
      FLD_IDLE: begin
        if (accept && i_fld_first) begin
          nxt_fld        = FLD_RUN;
          nxt_pos        = 9'h001;
          nxt_hdr        = '0;
          nxt_hdr[0]     = i_fld_bit;
          nxt_seg2       = cur_seg2;
        end
      end
      FLD_RUN: begin
        if (accept) begin
          if (i_fld_first) begin
            // a new field cut the old one short: restart on it
            nxt_pos    = 9'h001;
            nxt_hdr    = '0;
            nxt_hdr[0] = i_fld_bit;
            nxt_seg2   = cur_seg2;
          end else begin
            if (cur_pos < 9'(HDR_BITS)) begin
              nxt_hdr[cur_pos[2:0]] = i_fld_bit;
            end
            if (cur_pos == POS_FIELD_LAST) begin
              nxt_fld  = FLD_IDLE;
              nxt_pos  = '0;
            end else begin
              nxt_pos = cur_pos + 9'h001;
            end
          end
        end
      end
      default: begin
        nxt_fld = FLD_IDLE;
        nxt_pos = '0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      fld_ff   <= FLD_IDLE;
      pos_ff   <= '0;
      hdr_ff   <= '0;
      seg2_ff  <= 1'b0;
    end else begin
      fld_ff   <= nxt_fld;
      pos_ff   <= nxt_pos;
      hdr_ff   <= nxt_hdr;
      seg2_ff  <= nxt_seg2;
    end
  end

  // event flags kept apart from the field walk: done and abort are one-cycle reports, wait is raised for every cycle a bit waits on key with the buffer free
  always_comb begin
    nxt_done  = 1'b0;
    nxt_abort = 1'b0;
    nxt_wait  = i_fld_valid && buf_in_ready && key_use && !key_here;
    if (accept && (fld_ff == FLD_RUN)) begin
      nxt_abort = i_fld_first;
      nxt_done  = !i_fld_first && (cur_pos == POS_FIELD_LAST);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      done_ff  <= 1'b0;
      abort_ff <= 1'b0;
      wait_ff  <= 1'b0;
    end else begin
      done_ff  <= nxt_done;
      abort_ff <= nxt_abort;
      wait_ff  <= nxt_wait;
    end
  end

  // bits outside an open field are dropped; only a first bit opens one
  logic buf_push;
  assign buf_push = accept && ((fld_ff == FLD_RUN) || i_fld_first);

  // ciphered bits leave here so the framing logic builds its crcs over them
  sfk_buf2 #(
    .W (2)
  ) u_buf (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (buf_push),
    .i_in_data   ({i_fld_first, ciph_bit}),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (o_out_valid),
    .o_out_data  (buf_out),
    .i_out_ready (i_out_ready)
  );

  assign o_out_bit     = buf_out[0];
  assign o_out_first   = buf_out[1];
  assign o_frame_enc   = frm_enc_ff;
  assign o_field_done  = done_ff;
  assign o_field_abort = abort_ff;
  assign o_key_wait    = wait_ff;

endmodule

/* shared/sfk_pkg.sv */
package sfk_pkg;

  // slot field layout, bit positions in transmission order
  localparam int unsigned SLOT_BITS    = 388;
  localparam int unsigned FIRST_BITS   = 64;
  localparam int unsigned SECOND_BITS  = 324;
  localparam int unsigned HDR_BITS     = 8;
  localparam int unsigned TAIL_BITS    = 40;
  localparam int unsigned FCRC_BITS    = 16;
  localparam int unsigned DATA_BITS    = 320;
  localparam int unsigned XCRC_BITS    = 4;
  localparam int unsigned SUB_BITS     = 80;
  localparam int unsigned SUB_DATA     = 64;
  localparam int unsigned SCRC_BITS    = 16;

  localparam logic [8:0] POS_TAIL_FIRST = 9'h008;
  localparam logic [8:0] POS_TAIL_LAST  = 9'h02F;
  localparam logic [8:0] POS_DATA_FIRST = 9'h040;
  localparam logic [8:0] POS_DATA_LAST  = 9'h17F;
  localparam logic [8:0] POS_FIELD_LAST = 9'h183;

  // key stream segment layout
  localparam int unsigned SEG_BITS      = 360;
  localparam int unsigned PAIR_BITS     = 720;
  localparam logic [9:0]  SEG_SECOND    = 10'h168;
  localparam logic [9:0]  PAIR_LAST     = 10'h2CF;
  localparam logic [9:0]  KS_TAIL_BASE  = 10'h000;
  localparam logic [9:0]  KS_DATA_BASE  = 10'h028;

  // sub-block geometry: offset within an 80-bit sub-block
  localparam logic [6:0]  SUB_LEN       = 7'h50;
  localparam logic [6:0]  SUB_DATA_LEN  = 7'h40;

  // header codes
  localparam int unsigned HDR_TAIL_LSB  = 1;
  localparam int unsigned HDR_FMT_LSB   = 4;
  localparam logic [2:0]  TAIL_CTRL     = 3'h2;
  localparam logic [2:0]  FMT_UNPROT    = 3'h0;

  typedef enum logic [1:0] {
    FLD_IDLE = 2'b00,
    FLD_RUN  = 2'b01,
    FLD_HOLD = 2'b10
  } sfk_fld_t;

endpackage
